//--- src/ards_pkg.sv
// Purpose: Shared constants for the audio rate detect status block
// Assumes: 250 MHz core clock, AHB-Lite register access
// Notes:   Band limits in Hz, cycle bounds derived below
package ards_pkg;

    localparam int unsigned CLK_HZ      = 250_000_000;
    localparam int unsigned CNT_W       = 17;
    localparam int unsigned CODE_W      = 6;
    localparam int unsigned CODE_MAX    = 40;

    // Register indices; byte address is four times the index
    localparam logic [7:0]  IDX_STS0    = 8'h3E;
    localparam logic [7:0]  IDX_STS1    = 8'h3F;
    localparam logic [7:0]  IDX_CTRL    = 8'h50;
    localparam logic [11:0] ADDR_STS0   = {2'h0, IDX_STS0, 2'h0};
    localparam logic [11:0] ADDR_STS1   = {2'h0, IDX_STS1, 2'h0};
    localparam logic [11:0] ADDR_CTRL   = {2'h0, IDX_CTRL, 2'h0};

    // Field layout and reset values
    localparam int unsigned CODE_LSB    = 2;
    localparam int unsigned SYNTH_LSB   = 0;
    localparam logic [5:0]  CODE_RST    = 6'h00;
    localparam logic [1:0]  SYNTH_RST   = 2'h0;
    localparam logic [7:0]  STS1_RST    = 8'h00;
    localparam logic        CTRL_EN_RST = 1'b1;
    localparam int unsigned CTRL_EN_BIT = 0;

    localparam logic [1:0]  SYNTH_INT   = 2'h0;
    localparam logic [1:0]  SYNTH_FRAC  = 2'h1;
    localparam logic [1:0]  SYNTH_OFF   = 2'h2;

    localparam logic [1:0]  HTRANS_NSEQ = 2'h2;

    localparam int unsigned RATE_LO_HZ [41] = '{0,
        670320, 536256, 446880, 383040, 335160, 297920, 268128, 223440,
        191520, 167580, 148960, 134064, 111720, 95760, 83790, 74480,
        67032, 55860, 47880, 41895, 37240, 33516, 27930, 23940,
        20947, 18620, 16758, 13965, 11970, 10473, 9310, 8379,
        6982, 5985, 5236, 4655, 4189, 3491, 2992, 2618};
    localparam int unsigned RATE_HI_HZ [41] = '{0,
        791040, 632832, 527360, 452022, 395520, 351573, 316416, 263680,
        226011, 197760, 175786, 158208, 131840, 113005, 98880, 87893,
        79104, 65920, 56502, 49440, 43946, 39552, 32960, 28251,
        24720, 21973, 19776, 16480, 14125, 12360, 10986, 9888,
        8240, 7062, 6180, 5493, 4944, 4120, 3531, 3090};

    // Codes that win where neighbouring bands overlap
    localparam logic [63:0] PREFERRED   = 64'h0000_0152_9292_A52A;

    function automatic int unsigned minCycles(input int unsigned hiHz);
        return (CLK_HZ + hiHz - 1) / hiHz;
    endfunction : minCycles

    function automatic int unsigned maxCycles(input int unsigned loHz);
        return CLK_HZ / loHz;
    endfunction : maxCycles

    function automatic logic bandHit(input logic [CNT_W-1:0] period, input int unsigned code);
        int unsigned p;
        p = 32'(period);
        return (p >= minCycles(RATE_HI_HZ[code])) && (p <= maxCycles(RATE_LO_HZ[code]));
    endfunction : bandHit

    localparam logic [CNT_W-1:0] PERIOD_LIMIT = CNT_W'(maxCycles(RATE_LO_HZ[CODE_MAX]) + 1);

endpackage : ards_pkg

//--- src/ards_period_meter.sv
// Purpose: Frame period measurement on the primary audio port frame sync
// Assumes: Frame sync pin is asynchronous to clk
// Notes:   Period is clk cycles between rising frame edges
`timescale 1ns/1ns
module ards_period_meter
    import ards_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             frameSyncPin,
    input  wire logic             enable,
    output logic [CNT_W-1:0]      periodCnt_ff,
    output logic                  periodValid_ff,
    output logic                  halted_ff
);
    logic             sync1_ff;
    logic             sync2_ff;
    logic             sync3_ff;
    logic             armed_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic             rise;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            sync3_ff <= 1'b0;
        end else begin
            sync1_ff <= frameSyncPin;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    assign rise = sync2_ff & ~sync3_ff;

    // Saturating count; a stalled frame sync ends as a halt, not a wrap
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_ff         <= '0;
            armed_ff       <= 1'b0;
            periodCnt_ff   <= '0;
            periodValid_ff <= 1'b0;
            halted_ff      <= 1'b0;
        end else begin
            periodValid_ff <= 1'b0;
            halted_ff      <= 1'b0;
            if (!enable) begin
                armed_ff <= 1'b0;
                cnt_ff   <= '0;
            end else if (rise) begin
                cnt_ff   <= CNT_W'(1);
                armed_ff <= 1'b1;
                if (armed_ff) begin
                    periodCnt_ff   <= cnt_ff;
                    periodValid_ff <= 1'b1;
                end
            end else if (cnt_ff < PERIOD_LIMIT) begin
                cnt_ff <= cnt_ff + CNT_W'(1);
            end else if (armed_ff) begin
                armed_ff  <= 1'b0;
                halted_ff <= 1'b1;
            end
        end
    end

endmodule : ards_period_meter

//--- src/ards_rate_lookup.sv
// Purpose: Maps a measured frame period to a sample rate code
// Assumes: Period in clk cycles from the period meter
// Notes:   Preferred bands override overlapping neighbours
`timescale 1ns/1ns
module ards_rate_lookup
    import ards_pkg::*;
(
    input  wire logic [CNT_W-1:0]  period,
    output logic [CODE_W-1:0]      rateCode
);
    always_comb begin
        rateCode = CODE_RST;
        // Lowest matching ordinary band first
        for (int i = CODE_MAX; i >= 1; i--) begin
            if (bandHit(period, i) && !PREFERRED[i]) begin
                rateCode = CODE_W'(i);
            end
        end
        // Common rates win the overlaps
        for (int i = CODE_MAX; i >= 1; i--) begin
            if (bandHit(period, i) && PREFERRED[i]) begin
                rateCode = CODE_W'(i);
            end
        end
    end

endmodule : ards_rate_lookup

//--- src/ards_status_top.sv
// Purpose: Rate detect and synthesizer usage status behind AHB-Lite
// Assumes: Single-word transfers, zero-wait slave, OKAY only
// Notes:   Status is read-only; one control word enables detection
//
// Contract
// - Rate code is bits 7-2 of the status byte, read-only, resets zero.
// - Frame rate 670320..791040 Hz reports code 1 (768000 Hz).
// - Frame rate 83790..98880 Hz reports code 15 (96000 Hz).
// - Frame rate 41895..49440 Hz reports code 20, so 44100 too.
// - Frame rate 6982..8240 Hz reports code 33 (8000 Hz).
// - Code 40 is lowest valid; 0 and 41..63 never mean a rate.
// - Synth usage in bits 1-0, resets 00; zero means integer mode.
// - Synth usage 1 fractional, 2 unused, 3 reserved.
// - Second detect status byte reads 00 in its low bits.
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ns
module ards_status_top
    import ards_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic              hreadyout_ff,
    output logic              hresp_ff,
    output logic [31:0]       hrdata_ff,
    input  wire logic         frameSyncPin,
    input  wire logic         synthEnabled,
    input  wire logic         synthFracMode
);

    logic [CODE_W-1:0] rateCode_ff;
    logic [1:0]        synthUsage_ff;
    logic              detectEn_ff;
    logic              nxt_detectEn;
    logic              wrPend_ff;
    logic [11:0]       wrAddr_ff;
    logic              addrPhase;
    logic              addrOk;
    logic [11:0]       addrLow;
    logic [31:0]       nxt_hrdata;
    logic [CNT_W-1:0]  periodCnt;
    logic              periodValid;
    logic              halted;
    logic [CODE_W-1:0] lookupCode;
    logic [7:0]        sts0Byte;
    logic              ctrlWrite;

    // Address phase capture
    assign addrPhase = hsel && hready && (htrans == HTRANS_NSEQ || htrans == 2'h3);
    assign addrLow   = haddr[11:0];
    assign addrOk    = (haddr[31:12] == 20'h0_0000);
    assign ctrlWrite = wrPend_ff && (wrAddr_ff == ADDR_CTRL);

    // Bus never stalls and never errors
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hreadyout_ff <= 1'b1;
            hresp_ff     <= 1'b0;
        end else begin
            hreadyout_ff <= 1'b1;
            hresp_ff     <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wrPend_ff <= 1'b0;
            wrAddr_ff <= 12'h000;
        end else begin
            wrPend_ff <= addrPhase && hwrite && addrOk;
            wrAddr_ff <= addrLow;
        end
    end

    // Control word: only writable bit in the map
    always_comb begin
        nxt_detectEn = detectEn_ff;
        if (ctrlWrite) begin
            nxt_detectEn = hwdata[CTRL_EN_BIT];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            detectEn_ff <= CTRL_EN_RST;
        end else begin
            detectEn_ff <= nxt_detectEn;
        end
    end

    ards_period_meter uMeter (
        .clk            (clk),
        .reset          (reset),
        .frameSyncPin   (frameSyncPin),
        .enable         (detectEn_ff),
        .periodCnt_ff   (periodCnt),
        .periodValid_ff (periodValid),
        .halted_ff      (halted)
    );

    ards_rate_lookup uLookup (
        .period   (periodCnt),
        .rateCode (lookupCode)
    );

    // Code moves only on a measurement or a halt (cleared to zero); bus writes never reach it
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rateCode_ff <= CODE_RST;
        end else if (periodValid) begin
            rateCode_ff <= lookupCode;
        end else if (halted) begin
            rateCode_ff <= CODE_RST;
        end
    end

    // Synth state is a same-clock level, no synchroniser needed
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            synthUsage_ff <= SYNTH_RST;
        end else if (!synthEnabled) begin
            synthUsage_ff <= SYNTH_OFF;
        end else if (synthFracMode) begin
            synthUsage_ff <= SYNTH_FRAC;
        end else begin
            synthUsage_ff <= SYNTH_INT;
        end
    end

    assign sts0Byte = {rateCode_ff, synthUsage_ff};

    // Read data set up in the address phase, shown in the data phase
    always_comb begin
        nxt_hrdata = 32'h0000_0000;
        if (addrPhase && !hwrite && addrOk) begin
            case (addrLow)
                ADDR_STS0: nxt_hrdata = {24'h00_0000, sts0Byte};
                ADDR_STS1: nxt_hrdata = {24'h00_0000, STS1_RST};
                ADDR_CTRL: nxt_hrdata = {31'h0000_0000, nxt_detectEn};
                default:   nxt_hrdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hrdata_ff <= 32'h0000_0000;
        end else begin
            hrdata_ff <= nxt_hrdata;
        end
    end

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    logic inBand1;
    logic inBand15;
    logic inBand20;
    logic inBand33;
    logic inBand40;
    logic inAnyBand;

    assign inBand1  = bandHit(periodCnt, 1);
    assign inBand15 = bandHit(periodCnt, 15);
    assign inBand20 = bandHit(periodCnt, 20);
    assign inBand33 = bandHit(periodCnt, 33);
    assign inBand40 = bandHit(periodCnt, 40);

    // Own band scan, so the zero-code checks do not lean on the lookup
    always_comb begin
        inAnyBand = 1'b0;
        for (int unsigned i = 1; i <= CODE_MAX; i++) begin
            if (bandHit(periodCnt, i)) begin
                inAnyBand = 1'b1;
            end
        end
    end

    sequence readSts0_s;
        addrPhase && !hwrite && addrOk && addrLow == ADDR_STS0;
    endsequence

    sequence readSts1_s;
        addrPhase && !hwrite && addrOk && addrLow == ADDR_STS1;
    endsequence

    sequence writeSts0_s;
        addrPhase && hwrite && addrOk && addrLow == ADDR_STS0;
    endsequence

    sequence quietMeter_s;
        !periodValid && !halted;
    endsequence

    sequence writeSts1_s;
        addrPhase && hwrite && addrOk && addrLow == ADDR_STS1;
    endsequence

    sequence readCtrl_s;
        addrPhase && !hwrite && addrOk && addrLow == ADDR_CTRL;
    endsequence

    sequence readUnmapped_s;
        addrPhase && !hwrite && !(addrOk && (addrLow == ADDR_STS0 || addrLow == ADDR_STS1 || addrLow == ADDR_CTRL));
    endsequence

    sequence noRead_s;
        !(addrPhase && !hwrite);
    endsequence

    sequence enableWrite_s;
        ctrlWrite && hwdata[CTRL_EN_BIT];
    endsequence

    sequence disableWrite_s;
        ctrlWrite && !hwdata[CTRL_EN_BIT];
    endsequence

    property ctrlRead_p;
        readCtrl_s |=> hrdata_ff == {31'h0000_0000, $past(nxt_detectEn)};
    endproperty

    property idleData_p;
        noRead_s |=> hrdata_ff == 32'h0000_0000;
    endproperty

    property meterOff_p;
        !detectEn_ff |=> !periodValid && !halted;
    endproperty

    property codeHold_p;
        quietMeter_s |=> $stable(rateCode_ff);
    endproperty

    property gapZero_p;
        periodValid && !inAnyBand |=> rateCode_ff == CODE_RST;
    endproperty

    property bandCode_p;
        periodValid && inAnyBand |=> rateCode_ff != 6'h00;
    endproperty

    property codeAfterReset_p;
        $fell(reset) |-> rateCode_ff == CODE_RST && synthUsage_ff == SYNTH_RST;
    endproperty

    resetZero_a: assert property (codeAfterReset_p)
        else $error("status not zero after reset");

    codeField_a: assert property (readSts0_s |=> hrdata_ff[7:2] == $past(rateCode_ff))
        else $error("rate code not in bits 7-2");

    band768k_a: assert property (periodValid && inBand1 |=> rateCode_ff == 6'h01)
        else $error("768 kHz band did not give code 1");

    band96k_a: assert property (periodValid && inBand15 |=> rateCode_ff == 6'h0F)
        else $error("96 kHz band did not give code 15");

    band48k_a: assert property (periodValid && inBand20 |=> rateCode_ff == 6'h14)
        else $error("48 kHz band did not give code 20");

    band8k_a: assert property (periodValid ##0 inBand33 |=> rateCode_ff == 6'h21)
        else $error("8 kHz band did not give code 33");

    band3k_a: assert property (periodValid && inBand40 |=> rateCode_ff == 6'h28)
        else $error("3 kHz band did not give code 40");

    codeRange_a: assert property (rateCode_ff <= 6'h28)
        else $error("reserved rate code reported");

    haltClear_a: assert property (halted && !periodValid |=> rateCode_ff == 6'h00)
        else $error("halted frame sync kept a rate code");

    noBandZero_a: assert property (periodValid && rateCode_ff != 6'h00 ##1 rateCode_ff == 6'h00
                                   |-> !$past(inBand40) && !$past(inBand1))
        else $error("in-band period gave code 0");

    synthInt_a: assert property (synthEnabled && !synthFracMode |=> synthUsage_ff == 2'h0)
        else $error("integer synth not reported as 0");

    synthFrac_a: assert property (synthEnabled && synthFracMode |=> synthUsage_ff == 2'h1)
        else $error("fractional synth not reported as 1");

    synthOff_a: assert property (!synthEnabled |=> synthUsage_ff == 2'h2)
        else $error("unused synth not reported as 2");

    synthRsvd_a: assert property (synthUsage_ff != 2'h3)
        else $error("reserved synth value reported");

    synthField_a: assert property (readSts0_s |=> hrdata_ff[1:0] == $past(synthUsage_ff))
        else $error("synth usage not in bits 1-0");

    sts1Zero_a: assert property (readSts1_s |=> hrdata_ff == 32'h0000_0000)
        else $error("second status byte not zero");

    roWrite_a: assert property (writeSts0_s ##1 quietMeter_s |=> $stable(rateCode_ff))
        else $error("write changed read-only rate code");

    sts0Upper_a: assert property (readSts0_s |=> hrdata_ff[31:8] == 24'h00_0000)
        else $error("status read has upper bits set");

    ctrlRead_a: assert property (ctrlRead_p)
        else $error("control read returned wrong value");

    unmapRead_a: assert property (readUnmapped_s |=> hrdata_ff == 32'h0000_0000)
        else $error("unmapped read not zero");

    idleData_a: assert property (idleData_p)
        else $error("read data shown outside a read");

    enableSet_a: assert property (enableWrite_s |=> detectEn_ff)
        else $error("detect enable not set by write");

    enableClear_a: assert property (disableWrite_s |=> !detectEn_ff)
        else $error("detect enable not cleared by write");

    meterOff_a: assert property (meterOff_p)
        else $error("disabled meter produced an event");

    codeHold_a: assert property (codeHold_p)
        else $error("rate code moved without a measurement");

    sts1Write_a: assert property (writeSts1_s ##1 quietMeter_s |=> $stable(rateCode_ff))
        else $error("second status write changed rate code");

    gapZero_a: assert property (gapZero_p)
        else $error("out-of-band period gave a rate code");

    bandCode_a: assert property (bandCode_p)
        else $error("in-band period gave code 0");

    rate44k_a: assert property (periodValid && periodCnt == 17'h0_1625 |=> rateCode_ff == 6'h14)
        else $error("44.1 kHz frame did not give code 20");

    limitValid_a: assert property (periodValid |-> periodCnt <= PERIOD_LIMIT)
        else $error("measured period beyond halt limit");

    noStall_a: assert property (hreadyout_ff && !hresp_ff)
        else $error("slave stalled or errored");

endmodule : ards_status_top

//--- verification/test_audio_rate_detect_status.sv
// Purpose: Self-checking bench for the rate detect status block
// Assumes: Zero-wait AHB-Lite slave; frame sync driven by the bench
// Notes:   Slowest band left out, one frame there outlasts the run budget
`timescale 1ns/1ns
module test_audio_rate_detect_status
    import ards_pkg::*;
;
    typedef struct {
        int         period;
        logic       en;
        logic       frac;
        logic [5:0] code;
        logic [1:0] usage;
    } ards_row_s;

    logic        clk           = 1'b0;
    logic        reset         = 1'b1;
    logic        hsel          = 1'b0;
    logic [31:0] haddr         = 32'h0000_0000;
    logic [1:0]  htrans        = 2'h0;
    logic        hwrite        = 1'b0;
    logic [2:0]  hsize         = 3'h2;
    logic [31:0] hwdata        = 32'h0000_0000;
    logic        frameSyncPin  = 1'b0;
    logic        synthEnabled  = 1'b1;
    logic        synthFracMode = 1'b0;
    logic        hreadyOut;
    logic        hresp;
    logic [31:0] hrdata;
    logic [31:0] rd;
    int          miscompares   = 0;
    int          checksDone    = 0;
    int          framePeriod   = 326;
    event        frameEdge;

    // Band edges and overlaps chosen on purpose: 317/372 inside, 380 in a gap
    ards_row_s rows [9] = '{
        '{326,   1'b1, 1'b0, 6'h01, 2'h0},
        '{317,   1'b1, 1'b1, 6'h01, 2'h1},
        '{372,   1'b0, 1'b0, 6'h01, 2'h2},
        '{380,   1'b0, 1'b1, 6'h00, 2'h2},
        '{2604,  1'b1, 1'b0, 6'h0F, 2'h0},
        '{5208,  1'b1, 1'b1, 6'h14, 2'h1},
        '{5669,  1'b0, 1'b0, 6'h14, 2'h2},
        '{100,   1'b1, 1'b0, 6'h00, 2'h0},
        '{31250, 1'b1, 1'b1, 6'h21, 2'h1}};

    ards_status_top u_dut (
        .clk           (clk),
        .reset         (reset),
        .hsel          (hsel),
        .haddr         (haddr),
        .htrans        (htrans),
        .hwrite        (hwrite),
        .hsize         (hsize),
        .hwdata        (hwdata),
        .hready        (hreadyOut),
        .hreadyout_ff  (hreadyOut),
        .hresp_ff      (hresp),
        .hrdata_ff     (hrdata),
        .frameSyncPin  (frameSyncPin),
        .synthEnabled  (synthEnabled),
        .synthFracMode (synthFracMode)
    );

    always #2 clk = ~clk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            miscompares++;
        end
    endtask : check

    // Entered right after a rising edge; request held until hready is seen
    task automatic busXfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= HTRANS_NSEQ;
        hwrite <= wr;
        hsize  <= 3'h2;
        @(posedge clk);
        while (hreadyOut !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hreadyOut !== 1'b1) @(posedge clk);
        rd = hrdata;
        check({31'h0, hresp}, 32'h0000_0000);
    endtask : busXfer

    task automatic readCheck(input logic [31:0] a, input logic [31:0] exp);
        busXfer(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask : readCheck

    task automatic complete_run;
        if (miscompares == 0 && checksDone > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    // Frame sync source; period changes land before the low phase starts
    initial begin
        @(negedge reset);
        forever begin
            @(posedge clk);
            frameSyncPin <= 1'b1;
            -> frameEdge;
            repeat (40) @(posedge clk);
            frameSyncPin <= 1'b0;
            repeat (framePeriod - 41) @(posedge clk);
        end
    end

    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        complete_run();
    end

    initial begin
        repeat (6) @(posedge clk);
        check({29'h0, hreadyOut, hresp, 2'h0}, 32'h0000_0008);
        check(hrdata, 32'h0000_0000);
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        readCheck({20'h0, ADDR_STS0}, 32'h0000_0000);
        readCheck({20'h0, ADDR_STS1}, 32'h0000_0000);
        readCheck(32'h1000_00F8, 32'h0000_0000);
        readCheck(32'h0000_0200, 32'h0000_0000);
        @(frameEdge);
        foreach (rows[i]) begin
            framePeriod = rows[i].period;
            synthEnabled  <= rows[i].en;
            synthFracMode <= rows[i].frac;
            @(frameEdge);
            repeat (10) @(posedge clk);
            busXfer(1'b0, {20'h0, ADDR_STS0}, 32'h0000_0000);
            check(rd, {24'h0, rows[i].code, rows[i].usage});
        end
        // Status writes must not disturb the measured code
        busXfer(1'b1, {20'h0, ADDR_STS0}, 32'hFFFF_FFFF);
        readCheck({20'h0, ADDR_STS0}, 32'h0000_0085);
        busXfer(1'b1, {20'h0, ADDR_STS1}, 32'hFFFF_FFFF);
        readCheck({20'h0, ADDR_STS1}, 32'h0000_0000);
        busXfer(1'b1, {20'h0, ADDR_CTRL}, 32'h0000_0000);
        readCheck({20'h0, ADDR_CTRL}, 32'h0000_0000);
        readCheck({20'h0, ADDR_STS0}, 32'h0000_0085);
        busXfer(1'b1, {20'h0, ADDR_CTRL}, 32'hFFFF_FFFF);
        readCheck({20'h0, ADDR_CTRL}, 32'h0000_0001);
        // Second reset in mid-run clears the code, usage reloads from inputs
        reset <= 1'b1;
        repeat (3) @(posedge clk);
        check(hrdata, 32'h0000_0000);
        reset <= 1'b0;
        @(posedge clk);
        readCheck({20'h0, ADDR_STS0}, 32'h0000_0001);
        complete_run();
    end
endmodule : test_audio_rate_detect_status
